/* crg_defs.vh */
`ifndef CRG_DEFS_VH
`define CRG_DEFS_VH

// Register indices; byte address is four times the index
`define CRG_IDX_CHECKSUM 8'h23
`define CRG_IDX_DEV_CTRL 8'h25
`define CRG_IDX_PKT_FMT 8'h26
`define CRG_IDX_STATUS 8'hC0
`define CRG_IDX_MASK 8'hC1

// Covered range of the checksum scan
`define CRG_SCAN_HI 8'hB9
`define CRG_SCAN_LO 8'h25

// Reset values
`define CRG_RST_CHECKSUM 16'h0000
`define CRG_RST_DEV_CTRL 8'h11
`define CRG_RST_PKT_FMT 8'h01

// Checksum engine
`define CRG_POLY 16'h755B
`define CRG_SEED 16'hFFFF

// Device control fields
`define CRG_DC_SELFTEST 7
`define CRG_DC_TERM 4
`define CRG_DC_HALFBIAS 3
`define CRG_DC_REF_BUFFER_POWERDOWN 2
`define CRG_DC_REFSEL 1
`define CRG_DC_ECHO 0
`define CRG_DC_MASK 8'h9F

// Packet format fields
`define CRG_PF_PATTERN 2
`define CRG_PF_SIZE_HI 1
`define CRG_PF_SIZE_LO 0
`define CRG_PF_MASK 8'h07
`define CRG_SIZE_20 2'b00
`define CRG_SIZE_24 2'b01

// Status and mask fields
`define CRG_ST_CFG 0
`define CRG_ST_FUSE 1
`define CRG_ST_MASK 2'b11

`endif

/* crg_regs.v */
// Functional notes
// - Host writes 16-bit checksum over 0xB9 down to 0x25; resets zero.
// - Checksum is CRC-16 poly 0x755B, seeded with all ones.
// - Device rescans covered range continuously and compares with stored value.
// - Mismatch sets sticky corruption flag, cleared by writing one.
// - Self-test bit during conversions forces both error flags set.
// - Control bit 4 enables LVDS input termination; resets to one.
// - Control bit 3 selects LVDS half-bias output drive; resets zero.
// - Control bit 2 powers down reference buffer; resets zero.
// - Control bit 1 selects external reference, internal powered down.
// - Control bit 0 enables serial clock return echo; resets to one.
// - Pattern bit replaces conversion packets with channel pattern upper bits.
// - Size field 00 gives 20, 01 gives 24, else 32 bits.
// - Packet layout depends on width, oversampling and pattern mode.
//
// The APB register port was left to the implementer.
`include "crg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module crg_regs #(
  parameter AW = 10
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Conversion side
  input wire conv_active,
  input wire conv_valid,
  input wire [2:0] conv_channel,
  input wire [23:0] conv_data,
  input wire oversample_active,
  input wire [31:0] channel_fixed_pattern,
  input wire fuse_crc_error,
  // Packet output
  output reg pkt_valid,
  output reg [31:0] pkt_data,
  output reg [5:0] pkt_bits,
  // Analog and pad controls
  output reg lvds_term_en,
  output reg lvds_half_bias,
  output reg ref_buffer_powerdown,
  output reg ref_external_sel,
  output reg ref_internal_en,
  output reg clock_return_echo_en,
  // Interrupt
  output reg irq
);

  localparam ST_SCAN = 2'b01;
  localparam ST_CHECK = 2'b10;

  // Register file
  reg [15:0] checksum_reg;
  reg [7:0] dev_ctrl_reg;
  reg [7:0] pkt_fmt_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [7:0] cfg_mem [`CRG_SCAN_LO:`CRG_SCAN_HI];

  // Scan engine
  reg [1:0] state_reg;
  reg [7:0] scan_idx_reg;
  reg [15:0] crc_reg;
  reg [15:0] crc_next;
  reg mismatch;

  // Bus decode
  wire [7:0] idx = paddr[AW-1:2];
  wire access = psel & penable & ~pready;
  wire wr_commit = psel & penable & pready & pwrite;
  wire in_mem = (idx > `CRG_IDX_PKT_FMT) && (idx <= `CRG_SCAN_HI);
  reg mapped;
  reg [31:0] rdata;
  reg [1:0] status_next;

  // One CRC step over a byte, most significant bit first
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg fb;
    begin
      crc_byte = crc;
      for (i = 7; i >= 0; i = i - 1) begin
        fb = crc_byte[15] ^ data[i];
        crc_byte = {crc_byte[14:0], 1'b0} ^ (fb ? `CRG_POLY : 16'h0000);
      end
    end
  endfunction

  // Byte at a covered index
  function [7:0] cover_byte;
    input [7:0] i;
    begin
      if (i == `CRG_IDX_DEV_CTRL) begin
        cover_byte = dev_ctrl_reg;
      end else if (i == `CRG_IDX_PKT_FMT) begin
        cover_byte = pkt_fmt_reg;
      end else begin
        cover_byte = cfg_mem[i];
      end
    end
  endfunction

  // Read mux and address decode
  always @* begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (in_mem) begin
      rdata = {24'h00_0000, cfg_mem[idx]};
    end else begin
      case (idx)
        `CRG_IDX_CHECKSUM: rdata = {16'h0000, checksum_reg};
        `CRG_IDX_DEV_CTRL: rdata = {24'h00_0000, dev_ctrl_reg};
        `CRG_IDX_PKT_FMT: rdata = {24'h00_0000, pkt_fmt_reg};
        `CRG_IDX_STATUS: rdata = {30'h0000_0000, status_reg};
        `CRG_IDX_MASK: rdata = {30'h0000_0000, mask_reg};
        default: mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
      rdata = 32'h0000_0000;
    end
  end

  // APB answer one cycle into the access phase
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      prdata <= (access & ~pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // Host-written registers, reserved bits masked off
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      checksum_reg <= `CRG_RST_CHECKSUM;
      dev_ctrl_reg <= `CRG_RST_DEV_CTRL;
      pkt_fmt_reg <= `CRG_RST_PKT_FMT;
      mask_reg <= 2'b00;
    end else if (wr_commit && mapped) begin
      case (idx)
        `CRG_IDX_CHECKSUM: checksum_reg <= pwdata[15:0];
        `CRG_IDX_DEV_CTRL: dev_ctrl_reg <= pwdata[7:0] & `CRG_DC_MASK;
        `CRG_IDX_PKT_FMT: pkt_fmt_reg <= pwdata[7:0] & `CRG_PF_MASK;
        `CRG_IDX_MASK: mask_reg <= pwdata[1:0] & `CRG_ST_MASK;
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // Covered configuration bytes held in memory
  always @(posedge sys_clk) begin
    if (wr_commit && mapped && in_mem) begin
      cfg_mem[idx] <= pwdata[7:0];
    end
  end

  // Next CRC value for the byte under the scan pointer
  always @* begin
    crc_next = crc_byte(crc_reg, cover_byte(scan_idx_reg));
    mismatch = (crc_reg ^ {15'h0000, dev_ctrl_reg[`CRG_DC_SELFTEST] & conv_active})
      != checksum_reg;
  end

  // Continuous scan from top of range down, then compare
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_SCAN;
      scan_idx_reg <= `CRG_SCAN_HI;
      crc_reg <= `CRG_SEED;
    end else begin
      case (state_reg)
        ST_SCAN: begin
          crc_reg <= crc_next;
          if (scan_idx_reg == `CRG_SCAN_LO) begin
            state_reg <= ST_CHECK;
          end else begin
            scan_idx_reg <= scan_idx_reg - 8'h01;
          end
        end
        ST_CHECK: begin
          state_reg <= ST_SCAN;
          scan_idx_reg <= `CRG_SCAN_HI;
          crc_reg <= `CRG_SEED;
        end
        default: begin
          state_reg <= ST_SCAN;
          scan_idx_reg <= `CRG_SCAN_HI;
          crc_reg <= `CRG_SEED;
        end
      endcase
    end
  end

  // Sticky flags: set wins over write-one clear
  always @* begin
    status_next = status_reg;
    if (wr_commit && idx == `CRG_IDX_STATUS && paddr[1:0] == 2'b00) begin
      status_next = status_reg & ~pwdata[1:0];
    end
    if (state_reg == ST_CHECK && mismatch) begin
      status_next[`CRG_ST_CFG] = 1'b1;
    end
    if (fuse_crc_error || (dev_ctrl_reg[`CRG_DC_SELFTEST] && conv_active)) begin
      status_next[`CRG_ST_FUSE] = 1'b1;
    end
  end

  // Status and interrupt
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end

  // Pad and analog controls
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lvds_term_en <= 1'b1;
      lvds_half_bias <= 1'b0;
      ref_buffer_powerdown <= 1'b0;
      ref_external_sel <= 1'b0;
      ref_internal_en <= 1'b1;
      clock_return_echo_en <= 1'b1;
    end else begin
      lvds_term_en <= dev_ctrl_reg[`CRG_DC_TERM];
      lvds_half_bias <= dev_ctrl_reg[`CRG_DC_HALFBIAS];
      ref_buffer_powerdown <= dev_ctrl_reg[`CRG_DC_REF_BUFFER_POWERDOWN];
      ref_external_sel <= dev_ctrl_reg[`CRG_DC_REFSEL];
      ref_internal_en <= ~dev_ctrl_reg[`CRG_DC_REFSEL];
      clock_return_echo_en <= dev_ctrl_reg[`CRG_DC_ECHO];
    end
  end

  // Packet formatting
  wire [1:0] size = pkt_fmt_reg[`CRG_PF_SIZE_HI:`CRG_PF_SIZE_LO];
  wire pat_en = pkt_fmt_reg[`CRG_PF_PATTERN];
  reg [31:0] pkt_word;
  reg [5:0] pkt_width;

  always @* begin
    case (size)
      `CRG_SIZE_20: pkt_width = 6'd20;
      `CRG_SIZE_24: pkt_width = 6'd24;
      default: pkt_width = 6'd32;
    endcase
    case (size)
      `CRG_SIZE_20: begin
        if (pat_en) begin
          pkt_word = {12'h000, channel_fixed_pattern[31:12]};
        end else if (oversample_active) begin
          pkt_word = {12'h000, conv_data[23:4]};
        end else begin
          pkt_word = {12'h000, conv_data[19:0]};
        end
      end
      `CRG_SIZE_24: begin
        if (pat_en) begin
          pkt_word = {8'h00, channel_fixed_pattern[31:8]};
        end else if (oversample_active) begin
          pkt_word = {8'h00, conv_data};
        end else begin
          pkt_word = {8'h00, conv_data[19:0], 1'b0, conv_channel};
        end
      end
      default: begin
        if (pat_en) begin
          pkt_word = channel_fixed_pattern;
        end else if (oversample_active) begin
          pkt_word = {conv_data, 5'h00, conv_channel};
        end else begin
          pkt_word = {conv_data[19:0], 9'h000, conv_channel};
        end
      end
    endcase
  end

  // Registered packet output
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pkt_valid <= 1'b0;
      pkt_data <= 32'h0000_0000;
      pkt_bits <= 6'd24;
    end else begin
      pkt_valid <= conv_valid;
      pkt_bits <= pkt_width;
      if (conv_valid) begin
        pkt_data <= pkt_word;
      end
    end
  end

endmodule

`default_nettype wire

/* crg_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module crg_regs_chk (
  // Clock, reset, bus
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Packet and pad controls
  input wire logic conv_valid,
  input wire logic pkt_valid,
  input wire logic [31:0] pkt_data,
  input wire logic [5:0] pkt_bits,
  input wire logic lvds_term_en,
  input wire logic lvds_half_bias,
  input wire logic ref_buffer_powerdown,
  input wire logic ref_external_sel,
  input wire logic ref_internal_en,
  input wire logic clock_return_echo_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Setup cycle then access cycle
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  a_answer_next: assert property (s_req |=> pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_reset_vals: assert property ($rose(rstn) |-> lvds_term_en && clock_return_echo_en &&
    !lvds_half_bias && !ref_buffer_powerdown && pkt_bits == 24)
    else $error("bad reset value");
  a_ref_pair: assert property (ref_internal_en == !ref_external_sel)
    else $error("reference select mismatch");
  a_pkt_follow: assert property (conv_valid |=> pkt_valid)
    else $error("packet missing");
  a_pkt_width: assert property (pkt_valid |-> pkt_bits inside {20, 24, 32})
    else $error("bad packet width");
  a_pkt_hold: assert property (!conv_valid |=> !pkt_valid && $stable(pkt_data))
    else $error("packet changed without sample");
  a_err_zero: assert property (pready && pslverr |-> prdata == 0)
    else $error("refused access returned data");
endmodule
bind crg_regs crg_regs_chk u_chk (.sys_clk, .rstn, .psel, .penable, .prdata, .pready,
  .pslverr, .conv_valid, .pkt_valid, .pkt_data, .pkt_bits, .lvds_term_en, .lvds_half_bias,
  .ref_buffer_powerdown, .ref_external_sel, .ref_internal_en, .clock_return_echo_en);
`default_nettype wire

/* crg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module crg_host (
  // Clock
  input wire logic sys_clk,
  // Bus master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [9:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e, output logic ok);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Sample the answer at the rising edge only
    do begin
      @(posedge sys_clk);
      n++;
    end while (!pready && n < 20);
    r = prdata;
    e = pslverr;
    ok = pready;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h755b : 16'h0000);
    return c;
  endfunction
endmodule
`default_nettype wire

/* crg_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module crg_regs_test;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, conv_active, conv_valid;
  logic oversample_active, fuse_crc_error, pkt_valid, irq, e, ok;
  logic lvds_term_en, lvds_half_bias, ref_buffer_powerdown, ref_external_sel;
  logic ref_internal_en, clock_return_echo_en;
  logic [9:0] paddr;
  logic [2:0] conv_channel;
  logic [5:0] pkt_bits;
  logic [23:0] conv_data;
  logic [31:0] pwdata, prdata, channel_fixed_pattern, pkt_data, r, d;
  logic [7:0] mem [256];
  logic [7:0] ctrl_m, pkt_m;
  int num_errors, samples_checked;
  logic [7:0] idx_t [4] = '{8'h23, 8'h25, 8'h26, 8'hc1};
  logic [31:0] rst_t [4] = '{0, 8'h11, 8'h01, 0};

  crg_regs uut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_active, .conv_valid, .conv_channel, .conv_data,
    .oversample_active, .channel_fixed_pattern, .fuse_crc_error, .pkt_valid, .pkt_data,
    .pkt_bits, .lvds_term_en, .lvds_half_bias, .ref_buffer_powerdown, .ref_external_sel,
    .ref_internal_en, .clock_return_echo_en, .irq);
  crg_host u_host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);

  // Clock
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] v);
    u_host.xfer(w, {idx, 2'b00}, v, r, e, ok);
    if (!ok) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // Checksum of the covered range from the model
  function automatic logic [15:0] map_crc();
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 8'hb9; i >= 8'h25; i--)
      c = u_host.crc_step(c, i == 8'h25 ? ctrl_m : i == 8'h26 ? pkt_m : mem[i]);
    return c;
  endfunction

  // Main sequence
  initial begin
    {rstn, conv_active, conv_valid, oversample_active, fuse_crc_error} = '0;
    {conv_channel, conv_data, channel_fixed_pattern} = '0;
    void'($urandom(32'h341f));
    repeat (6) @(posedge sys_clk);
    rstn <= 1;
    @(posedge sys_clk);
    foreach (idx_t[i]) begin
      bus(0, idx_t[i], 0);
      check("reset value", r, rst_t[i]);
    end
    repeat (4) begin
      d = $urandom;
      ctrl_m = d[7:0] & 8'h9f;
      bus(1, 8'h25, d);
      bus(0, 8'h25, 0);
      check("control", r, ctrl_m);
      check("pads", {lvds_term_en, lvds_half_bias, ref_buffer_powerdown, ref_external_sel,
        ref_internal_en, clock_return_echo_en}, {ctrl_m[4:1], !ctrl_m[1], ctrl_m[0]});
    end
    foreach (rst_t[i]) begin
      u_host.xfer(i[0], i[1] ? 10'h3fc : 10'h095, '1, r, e, ok);
      check("refused", {e, r[30:0]}, 32'h8000_0000);
      check("refused answer", ok, 1);
    end
    for (int f = 0; f < 16; f++) begin
      pkt_m = f[2:0];
      bus(1, 8'h26, {f[3], 4'hf, f[2:0]});
      bus(0, 8'h26, 0);
      check("format", r, pkt_m);
      d = $urandom;
      conv_valid <= 1;
      oversample_active <= f[3];
      conv_channel <= d[2:0];
      conv_data <= d[31:8];
      channel_fixed_pattern <= ~d;
      @(posedge sys_clk);
      conv_valid <= 0;
      @(negedge sys_clk);
      check("pkt valid", pkt_valid, 1);
      check("pkt bits", pkt_bits, f[1:0] == 0 ? 20 : f[1:0] == 1 ? 24 : 32);
      case (f[1:0])
        0: check("pkt", pkt_data, f[2] ? channel_fixed_pattern[31:12] :
          f[3] ? d[31:12] : d[27:8]);
        1: check("pkt", pkt_data, f[2] ? channel_fixed_pattern[31:8] :
          f[3] ? d[31:8] : {d[27:8], 1'b0, d[2:0]});
        default: check("pkt", pkt_data, f[2] ? channel_fixed_pattern :
          f[3] ? {d[31:8], 5'h00, d[2:0]} : {d[27:8], 9'h000, d[2:0]});
      endcase
      @(posedge sys_clk);
    end
    for (int i = 8'h27; i <= 8'hb9; i++) begin
      mem[i] = $urandom;
      bus(1, i[7:0], mem[i]);
    end
    // Checksum, mask, then four stages: clean, corrupted, self test while idle, self test during conversion
    for (int s = 0; s < 4; s++) begin
      if (s == 1) mem[8'h60] = ~mem[8'h60];
      if (s == 3) conv_active <= 1;
      ctrl_m[7] = s[1];
      bus(1, 8'h60, mem[8'h60]);
      bus(1, 8'h25, ctrl_m);
      bus(1, 8'h23, s == 1 ? ~map_crc() : map_crc());
      bus(1, 8'hc1, 1);
      // Let any scan that mixed old and new bytes finish before clearing
      repeat (160) @(posedge sys_clk);
      bus(1, 8'hc0, 3);
      repeat (310) @(posedge sys_clk);
      bus(0, 8'hc0, 0);
      check("status", r, s == 3 ? 3 : s == 1);
      check("irq", irq, s == 1 || s == 3);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
